/* File: hrah_pkg.sv */
// hrah_pkg: constants shared by both ends of the host register port.
// assumes a single 100 MHz system clock; video clock derived by enable.
package hrah_pkg;
  localparam int CLK_NS          = 10;
  localparam int VIDEO_CLOCK_DIV        = 4;     // video clock enable every 4 clk
  localparam int ADR_W           = 2;
  localparam int DATA_W          = 32;
  localparam logic [1:0] ADR_CDATA = 2'h0;
  localparam logic [1:0] ADR_IADR  = 2'h1;
  localparam logic [1:0] ADR_IDATA = 2'h2;
  localparam logic [1:0] ADR_IRQ   = 2'h3;
  // device answer latencies, in video clock periods
  localparam int RD_DATA_VIDEO_CLOCK    = 4;
  localparam int RD_ACK_VIDEO_CLOCK     = 7;
  localparam int WR_ACK_VIDEO_CLOCK     = 4;
  localparam int STALL_VIDEO_CLOCK      = 52;
  // host side least times
  localparam int CD_CYC_NS       = 28;
  localparam int CD_PW_NS        = 10;
  localparam int CD_PW_CYC       = (CD_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CD_CYC_CYC      = (CD_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD2WR_NS        = 49;    // 1.5 video_clock - 4.1 ns, rounded up
  localparam int WR2RD_NS        = 36;    // 0.8 video_clock + 7.4 ns, rounded up
  localparam int RD2WR_CYC       = (RD2WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR2RD_CYC       = (WR2RD_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_WAIT = 3'b001, HS_ACK = 3'b010,
    HS_REL  = 3'b011, HS_GAP  = 3'b100
  } hrah_state_t;
endpackage

/* File: hrah_if.sv */
// hrah_if: host port pins between host end and device end.
// assumes both ends on clk; data bus resolved here from enables.
`timescale 1ns/1ns
interface hrah_if;
  logic                           csN;
  logic                           rdN;
  logic                           wrN;
  logic [hrah_pkg::ADR_W-1:0]     adr;
  logic [hrah_pkg::DATA_W-1:0]    hostDout;
  logic                           hostDoeN;
  logic [hrah_pkg::DATA_W-1:0]    devDout;
  logic                           devDoeN;
  logic                           ackN;
  logic                           statisticsReady;
  wire  [hrah_pkg::DATA_W-1:0]    data = !hostDoeN ? hostDout :
                                         !devDoeN  ? devDout  : '0;
  modport dev  (input csN, rdN, wrN, adr, data,
                output devDout, devDoeN, ackN, statisticsReady);
  modport host (input ackN, data, statisticsReady,
                output csN, rdN, wrN, adr, hostDout, hostDoeN);
endinterface

/* File: hrah_device.sv */
// hrah_device: device end, answers strobes with acknowledge.
// assumes host strobes synchronous to clk; slow registers are plain storage, CDATA is not.
`timescale 1ns/1ns
module hrah_device #(
  parameter int DATA_W = hrah_pkg::DATA_W
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  hrah_if.dev        bus,
  input  wire logic  statsReadyIn,
  input  wire logic [DATA_W-1:0] cdataIn,
  output logic [DATA_W-1:0] cdataOut,
  output logic       cdataWrStb,
  output logic       cdataRdStb
);
  hrah_pkg::hrah_state_t state_q;
  hrah_pkg::hrah_state_t state_d;
  logic [1:0]            div_q;
  logic [1:0]            div_d;
  logic [5:0]            vcnt_q;
  logic [5:0]            vcnt_d;
  logic [DATA_W-1:0]     iadr_q;
  logic [DATA_W-1:0]     iadr_d;
  logic [DATA_W-1:0]     idata_q;
  logic [DATA_W-1:0]     idata_d;
  logic [DATA_W-1:0]     irq_q;
  logic [DATA_W-1:0]     irq_d;
  logic [DATA_W-1:0]     rdData_q;
  logic [DATA_W-1:0]     rdData_d;
  logic [DATA_W-1:0]     cdata_q;
  logic [DATA_W-1:0]     cdata_d;
  logic                  ackN_q;
  logic                  ackN_d;
  logic                  doeN_q;
  logic                  doeN_d;
  logic                  stats_q;
  logic                  wrStb_q;
  logic                  wrStb_d;
  logic                  rdStb_q;
  logic                  rdStb_d;

  // stall overrides every slow-access latency while statistics are not ready; the CDATA fast path is not stalled
  function automatic logic [5:0] limitFor(input logic       stalled,
                                          input logic [5:0] normal);
    return stalled ? 6'(hrah_pkg::STALL_VIDEO_CLOCK) : normal;
  endfunction

  wire       rdA     = !bus.csN && !bus.rdN;
  wire       wrA     = !bus.csN && !bus.wrN;
  wire       strobe  = rdA || wrA;
  wire       isCd    = bus.adr == hrah_pkg::ADR_CDATA;
  wire       fastHit = strobe && isCd;
  wire       vEn     = div_q == 2'(hrah_pkg::VIDEO_CLOCK_DIV - 1);
  wire [5:0] ackNorm = rdA ? 6'(hrah_pkg::RD_ACK_VIDEO_CLOCK)
                           : 6'(hrah_pkg::WR_ACK_VIDEO_CLOCK);
  wire [5:0] ackLim  = limitFor(!stats_q, ackNorm);
  wire [5:0] datLim  = limitFor(!stats_q,
                                6'(hrah_pkg::RD_DATA_VIDEO_CLOCK));
  // counter compares against limit minus one: answer lands on the limit
  wire       datDue  = rdA && vcnt_q >= datLim - 6'h1;
  wire       ackDue  = vcnt_q >= ackLim - 6'h1;
  wire [DATA_W-1:0] slowRd = bus.adr == hrah_pkg::ADR_IADR  ? iadr_q  :
                             bus.adr == hrah_pkg::ADR_IDATA ? idata_q :
                             irq_q;

  assign bus.ackN            = ackN_q;
  assign bus.devDoeN         = doeN_q;
  assign bus.devDout         = rdData_q;
  assign bus.statisticsReady = stats_q;
  assign cdataOut            = cdata_q;
  assign cdataWrStb          = wrStb_q;
  assign cdataRdStb          = rdStb_q;

  assign div_d = vEn ? 2'h0 : div_q + 2'h1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end

  always_comb begin
    state_d  = state_q;
    vcnt_d   = vcnt_q;
    ackN_d   = ackN_q;
    doeN_d   = doeN_q;
    rdData_d = rdData_q;
    iadr_d   = iadr_q;
    idata_d  = idata_q;
    irq_d    = irq_q;
    cdata_d  = cdata_q;
    wrStb_d  = 1'b0;
    rdStb_d  = 1'b0;
    case (state_q)
      hrah_pkg::HS_IDLE: begin
        vcnt_d = 6'h0;
        if (fastHit) begin
          // fast path: answer next cycle, no video wait
          ackN_d  = 1'b0;
          state_d = hrah_pkg::HS_ACK;
          if (rdA) begin
            rdData_d = cdataIn;
            doeN_d   = 1'b0;
            rdStb_d  = 1'b1;
          end else begin
            cdata_d = bus.data;
            wrStb_d = 1'b1;
          end
        end else if (strobe) begin
          state_d = hrah_pkg::HS_WAIT;
        end
      end
      hrah_pkg::HS_WAIT: begin
        if (!strobe) begin
          // strobe dropped early: abandon, nothing written
          doeN_d  = 1'b1;
          state_d = hrah_pkg::HS_IDLE;
        end else begin
          if (vEn) begin
            vcnt_d = vcnt_q + 6'h1;
          end
          if (datDue) begin
            rdData_d = slowRd;
            doeN_d   = 1'b0;
          end
          if (ackDue) begin
            ackN_d  = 1'b0;
            state_d = hrah_pkg::HS_ACK;
            if (wrA) begin
              case (bus.adr)
                hrah_pkg::ADR_IADR:  iadr_d  = bus.data;
                hrah_pkg::ADR_IDATA: idata_d = bus.data;
                default:             irq_d   = bus.data;
              endcase
            end
          end
        end
      end
      hrah_pkg::HS_ACK: begin
        if (!strobe) begin
          ackN_d  = 1'b1;
          doeN_d  = 1'b1;
          state_d = hrah_pkg::HS_IDLE;
        end
      end
      default: begin
        state_d = hrah_pkg::HS_IDLE;
      end
    endcase
  end

  // control state and pin drivers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= hrah_pkg::HS_IDLE;
      vcnt_q  <= 6'h0;
      ackN_q  <= 1'b1;
      doeN_q  <= 1'b1;
      stats_q <= 1'b1;
      wrStb_q <= 1'b0;
      rdStb_q <= 1'b0;
    end else begin
      state_q <= state_d;
      vcnt_q  <= vcnt_d;
      ackN_q  <= ackN_d;
      doeN_q  <= doeN_d;
      stats_q <= statsReadyIn;
      wrStb_q <= wrStb_d;
      rdStb_q <= rdStb_d;
    end
  end

  // register storage; plain words, only CDATA access pulses a strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdData_q <= 32'h0000_0000;
      iadr_q   <= 32'h0000_0000;
      idata_q  <= 32'h0000_0000;
      irq_q    <= 32'h0000_0000;
      cdata_q  <= 32'h0000_0000;
    end else begin
      rdData_q <= rdData_d;
      iadr_q   <= iadr_d;
      idata_q  <= idata_d;
      irq_q    <= irq_d;
      cdata_q  <= cdata_d;
    end
  end
endmodule // hrah_device

/* File: hrah_host.sv */
// hrah_host: host end, turns user requests into strobe handshakes.
// assumes device end on the same clk; one request in flight.
`timescale 1ns/1ns
module hrah_host #(
  parameter int DATA_W = hrah_pkg::DATA_W
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  hrah_if.host       bus,
  input  wire logic  reqValid,
  input  wire logic  reqWrite,
  input  wire logic [hrah_pkg::ADR_W-1:0] reqAdr,
  input  wire logic [DATA_W-1:0] reqData,
  output logic       reqReady,
  output logic       rspValid,
  output logic [DATA_W-1:0] rspData
);
  hrah_pkg::hrah_state_t state_q;
  logic [3:0]        cnt_q;
  logic              csN_q, rdN_q, wrN_q, doeN_q, lastWr_q, cd_q;
  logic              ready_q, rspV_q;
  logic [hrah_pkg::ADR_W-1:0] adr_q;
  logic [DATA_W-1:0] dout_q, rsp_q;

  wire isCd = reqAdr == hrah_pkg::ADR_CDATA;
  // turnaround guard after a slow access of the other direction
  wire [3:0] gap = lastWr_q ? 4'(hrah_pkg::WR2RD_CYC)
                            : 4'(hrah_pkg::RD2WR_CYC);

  assign bus.csN      = csN_q;
  assign bus.rdN      = rdN_q;
  assign bus.wrN      = wrN_q;
  assign bus.adr      = adr_q;
  assign bus.hostDout = dout_q;
  assign bus.hostDoeN = doeN_q;
  assign reqReady     = ready_q;
  assign rspValid     = rspV_q;
  assign rspData      = rsp_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q  <= hrah_pkg::HS_IDLE;
      cnt_q    <= 4'h0;
      csN_q    <= 1'b1;
      rdN_q    <= 1'b1;
      wrN_q    <= 1'b1;
      doeN_q   <= 1'b1;
      lastWr_q <= 1'b0;
      cd_q     <= 1'b0;
      ready_q  <= 1'b1;
      rspV_q   <= 1'b0;
      adr_q    <= 2'h0;
      dout_q   <= 32'h0000_0000;
      rsp_q    <= 32'h0000_0000;
    end else begin
      rspV_q <= 1'b0;
      case (state_q)
        hrah_pkg::HS_IDLE: begin
          if (reqValid && ready_q) begin
            ready_q  <= 1'b0;
            csN_q    <= 1'b0;
            adr_q    <= reqAdr;
            dout_q   <= reqData;
            doeN_q   <= !reqWrite;
            rdN_q    <= reqWrite;
            wrN_q    <= !reqWrite;
            lastWr_q <= reqWrite;
            cd_q     <= isCd;
            cnt_q    <= 4'h0;
            state_q  <= hrah_pkg::HS_WAIT;
          end
        end
        hrah_pkg::HS_WAIT: begin
          cnt_q <= cnt_q + 4'h1;
          // compressed: timed pulse; slow: wait for acknowledge
          // pulse kept one cycle longer so the fast answer is on the bus
          if ((cd_q && cnt_q >= 4'(hrah_pkg::CD_PW_CYC)) ||
              (!cd_q && !bus.ackN)) begin
            if (!rdN_q) begin
              rsp_q  <= bus.data;
              rspV_q <= 1'b1;
            end
            rdN_q   <= 1'b1;
            wrN_q   <= 1'b1;
            csN_q   <= 1'b1;
            doeN_q  <= 1'b1;
            cnt_q   <= 4'h0;
            state_q <= cd_q ? hrah_pkg::HS_GAP : hrah_pkg::HS_REL;
          end
        end
        hrah_pkg::HS_REL: begin
          if (bus.ackN) begin
            cnt_q   <= 4'h0;
            state_q <= hrah_pkg::HS_GAP;
          end
        end
        hrah_pkg::HS_GAP: begin
          cnt_q <= cnt_q + 4'h1;
          // compressed skips the ack wait, keeps deasserted width
          if ((cd_q && cnt_q >= 4'(hrah_pkg::CD_PW_CYC - 1)) ||
              (!cd_q && cnt_q >= gap - 4'h1)) begin
            ready_q <= 1'b1;
            state_q <= hrah_pkg::HS_IDLE;
          end
        end
        default: state_q <= hrah_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // hrah_host

/* File: hrah_asserts.sv */
// hrah_asserts: timing checks on the host port pins.
// assumes interface pins handed in as plain inputs, one clk domain.
`timescale 1ns/1ns
module hrah_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       csN,
  input wire logic       rdN,
  input wire logic       wrN,
  input wire logic [1:0] adr,
  input wire logic       devDoeN,
  input wire logic       ackN,
  input wire logic       statisticsReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic slow = (adr != hrah_pkg::ADR_CDATA);
  // bounds carry margin for the strobe sync and video_clock enable phase
  sequence s_srd; $fell(rdN) && !csN && slow && statisticsReady; endsequence
  sequence s_swr; $fell(wrN) && !csN && slow && statisticsReady; endsequence
  sequence s_any; $fell(rdN && wrN) && !csN && slow; endsequence
  property p_rd_data; s_srd |-> ##[1:22] !devDoeN; endproperty
  property p_rd_ack; s_srd |-> ##[1:34] !ackN; endproperty
  property p_wr_ack; s_swr |-> ##[1:22] !ackN; endproperty
  property p_stall; s_any |-> ##[1:214] !ackN; endproperty
  property p_fast; $fell(rdN) && !csN && !slow |-> ##[1:2] !ackN; endproperty
  property p_rel; rdN && wrN |=> ackN; endproperty
  property p_cause; $fell(ackN) |-> !$past(rdN) || !$past(wrN); endproperty
  property p_hold;
    !csN && slow && ackN && !(rdN && wrN) |=> !(rdN && wrN) && $stable(adr);
  endproperty
  property p_rd2wr; $rose(rdN) && slow |-> wrN [*5]; endproperty
  property p_wr2rd; $rose(wrN) && slow |-> rdN [*4]; endproperty
  a_rd_data: assert property (p_rd_data) else $error("late read data");
  a_rd_ack: assert property (p_rd_ack) else $error("late read ack");
  a_wr_ack: assert property (p_wr_ack) else $error("late write ack");
  a_stall: assert property (p_stall) else $error("stall too long");
  a_fast: assert property (p_fast) else $error("late fast ack");
  a_rel: assert property (p_rel) else $error("ack not released");
  a_cause: assert property (p_cause) else $error("ack w/o strobe");
  a_hold: assert property (p_hold) else $error("strobe dropped");
  a_rd2wr: assert property (p_rd2wr) else $error("short rd-wr gap");
  a_wr2rd: assert property (p_wr2rd) else $error("short wr-rd gap");
endmodule // hrah_asserts

/* File: host_register_access_handshake_test.sv */
// host_register_access_handshake_test: host end joined to device end.
// assumes slow registers are plain storage; inputs driven at negedge.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module host_register_access_handshake_test;
  logic        clk = 0, resetn = 0, reqValid = 0, reqWrite = 0;
  logic        statsReadyIn = 1, reqReady, rspValid, cdataWrStb, cdataRdStb;
  logic [1:0]  reqAdr = '0;
  logic [31:0] reqData = '0, cdataIn = '0, rspData, cdataOut;
  logic [31:0] rnd = 32'h0000_6a06, d;
  logic [31:0] mem [4];
  int          n_mismatch = 0, cmp_count = 0, nWr = 0, nRd = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (cdataWrStb === 1'b1) nWr++;
    if (cdataRdStb === 1'b1) nRd++;
  end
  hrah_if bus ();
  hrah_host hrah_host_inst (.clk(clk), .resetn(resetn), .bus(bus),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAdr(reqAdr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData));
  hrah_device hrah_device_inst (.clk(clk), .resetn(resetn), .bus(bus),
    .statsReadyIn(statsReadyIn), .cdataIn(cdataIn), .cdataOut(cdataOut),
    .cdataWrStb(cdataWrStb), .cdataRdStb(cdataRdStb));
  hrah_asserts hrah_asserts_inst (.clk(clk), .resetn(resetn),
    .csN(bus.csN), .rdN(bus.rdN), .wrN(bus.wrN), .adr(bus.adr),
    .devDoeN(bus.devDoeN), .ackN(bus.ackN),
    .statisticsReady(bus.statisticsReady));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait; stall reads need over 200 cycles
  task automatic waitFor(ref logic s);
    for (int i = 0; s !== 1'b1; i++) begin
      if (i == 400) begin n_mismatch++; summarize(); end
      @(negedge clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [1:0] a);
    logic [31:0] e;
    @(negedge clk);
    waitFor(reqReady);
    reqValid = 1;
    reqWrite = w;
    reqAdr = a;
    reqData = d;
    @(negedge clk);
    reqValid = 0;
    e = (a == 2'h0) ? cdataIn : mem[a];
    if (w) mem[a] = d;
    else begin
      waitFor(rspValid);
      `CHK(rspData, e)
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1;
    for (int a = 1; a < 4; a++) begin
      rnd = xs(rnd);
      d = rnd;
      xfer(1, a[1:0]);
      xfer(0, a[1:0]);
    end
    $display("test slow done");
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      d = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0000_0000 : rnd;
      xfer(1, 2'h0);
      cdataIn = ~rnd;
      xfer(0, 2'h0);
      `CHK(cdataOut, d)
    end
    `CHK(nWr, 8)
    `CHK(nRd, 8)
    $display("test fast done");
    statsReadyIn = 0;
    repeat (3) @(negedge clk);
    rnd = xs(rnd);
    d = rnd;
    xfer(1, 2'h3);
    xfer(0, 2'h3);
    statsReadyIn = 1;
    $display("test stall done");
    waitFor(reqReady);
    summarize();
  end
endmodule // host_register_access_handshake_test
